// File: logic/wake_event_logic.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Bus power event wakes from S1 or S3; from S5 only with jumper fitted.
// [RQ2] Serial bus activity wakes only from S1 or S3.
// [RQ3] Keyboard activity wakes from S1 or S3.
// [RQ4] Mouse activity wakes only from S1; ignored in deeper states.
// [RQ5] Network adapter raises its wake line on seeing the wake frame.
// [RQ6] Network connector wake accepted only in APM off or S5.
// [RQ7] Newer network adapters wake through the bus power event line.
// [RQ8] Any permitted wake returns the system to working state.
// [RQ9] In S3 supply and fans stay off; indicator amber or dark.
// [RQ10] Standby indicator lit while standby power feeds memory and slots.
// [RQ11] Ring wake powers up the system from APM soft-off.
// [RQ12] Ring wake: first call restores, second call grants access.
// [RQ13] Only first serial port ring indicator wakes; second port ignored.
// [RQ14] Internal modem ring accepted through dedicated ring connector.
// [RQ15] Ring resume wakes from APM sleep or S1 on a call.
// [RQ16] Ring resume grants access on the first call.
// [RQ17] Ring resume treats modems alike; ignores ring connector.
// [RQ18] Software keeps modem interrupt unmasked for ring resume.
// [RQ19] Enabled sources merge into one request; barred sources ignored.
module wake_event_logic
(
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                sleep_req,
   input  wire wake_pkg::pwr_state_e sleep_target,
   input  wire logic                pme_n,
   input  wire logic                usb_activity,
   input  wire logic                kbd_activity,
   input  wire logic                mouse_activity,
   input  wire logic                lan_wake,
   input  wire logic                ring_port_a,
   input  wire logic                ring_port_b,
   input  wire logic                ring_connector,
   input  wire logic                modem_irq,
   input  wire logic                s5_jumper,
   input  wire logic                led_dual_colour,
   input  wire logic                standby_present,
   input  wire logic                access_ack,
   output wake_pkg::pwr_state_e     state,
   output logic                     main_power_on,
   output logic                     fans_on,
   output logic [1:0]               front_led,
   output logic                     standby_led,
   output logic                     wake_pulse,
   output logic                     access_grant
);
   import wake_pkg::*;

   logic [NUM_SRC-1:0] raw_in;
   logic [NUM_SRC-1:0] sync_in;
   logic [NUM_SRC-1:0] prev_reg;
   logic [NUM_SRC-1:0] prev_next;
   logic [NUM_SRC-1:0] rise;
   logic               jumper_s;
   logic               dual_s;
   logic               standby_s;
   logic [2:0]         cfg_meta_reg;
   logic [2:0]         cfg_meta_next;
   logic [2:0]         cfg_sync_reg;
   logic [2:0]         cfg_sync_next;

   pwr_state_e         state_reg;
   pwr_state_e         state_next;
   logic               power_reg;
   logic               power_next;
   logic [1:0]         led_reg;
   logic [1:0]         led_next;
   logic               sbled_reg;
   logic               sbled_next;
   logic               wake_reg;
   logic               wake_next;
   logic               grant_reg;
   logic               grant_next;
   logic [1:0]         calls_reg;
   logic [1:0]         calls_next;
   logic               wake_req;
   logic               ring_any;

   assign raw_in = {modem_irq, ring_connector, ring_port_b, ring_port_a,
                    lan_wake, mouse_activity, kbd_activity, usb_activity,
                    ~pme_n};

   sync_bank #(.WIDTH(NUM_SRC)) u_sync
   (
      .clk      (clk),
      .reset    (reset),
      .async_in (raw_in),
      .sync_out (sync_in)
   );

   // Straps and standby sense are slow levels but still cross domains.
   always_comb
   begin
      cfg_meta_next = {s5_jumper, led_dual_colour, standby_present};
      cfg_sync_next = cfg_meta_reg;
      prev_next     = sync_in;
      if (reset)
      begin
         cfg_meta_next = '0;
         cfg_sync_next = '0;
         prev_next     = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      cfg_meta_reg <= cfg_meta_next;
      cfg_sync_reg <= cfg_sync_next;
      prev_reg     <= prev_next;
   end

   assign jumper_s  = cfg_sync_reg[2];
   assign dual_s    = cfg_sync_reg[1];
   assign standby_s = cfg_sync_reg[0];
   // Edges only, so a line held active before sleep cannot wake at once.
   assign rise      = sync_in & ~prev_reg;

   function automatic logic is_s1s3(input pwr_state_e s);
      is_s1s3 = (s == ST_S1) || (s == ST_S3);
   endfunction : is_s1s3

   function automatic logic sleep_led(input logic dual);
      sleep_led = dual;
   endfunction : sleep_led

   // Ring wake sources: port A and ring connector; port B never counts.
   assign ring_any = rise[SRC_RING_A] | rise[SRC_RINGCON]; // RQ13 RQ14

   always_comb
   begin
      wake_req = 1'b0;
      case (state_reg)
         ST_S1:
         begin
            wake_req = rise[SRC_PME] | rise[SRC_USB] | rise[SRC_KBD]
                     | rise[SRC_MOUSE] | rise[SRC_RING_A]
                     | rise[SRC_MODIRQ]; // RQ1 RQ2 RQ3 RQ4 RQ15 RQ17 RQ19
         end
         ST_S3:
         begin
            wake_req = rise[SRC_PME] | rise[SRC_USB]
                     | rise[SRC_KBD]; // RQ1 RQ2 RQ3 RQ4 RQ19
         end
         ST_S5:
         begin
            wake_req = (rise[SRC_PME] & jumper_s)
                     | rise[SRC_LANCON]; // RQ1 RQ6 RQ7
         end
         ST_APM_OFF:
         begin
            wake_req = rise[SRC_LANCON] | ring_any; // RQ6 RQ11
         end
         ST_APM_SLP:
         begin
            wake_req = rise[SRC_RING_A] | rise[SRC_MODIRQ]; // RQ15 RQ17
         end
         default:
         begin
            wake_req = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      state_next = state_reg;
      wake_next  = 1'b0;
      calls_next = calls_reg;
      grant_next = grant_reg;
      if (state_reg == ST_WORK)
      begin
         if (access_ack)
         begin
            grant_next = 1'b0;
         end
         // Second call after a ring wake grants access.
         if ((calls_reg != 2'h0) && ring_any)
         begin
            calls_next = 2'h0;
            grant_next = 1'b1; // RQ12
         end
         if (sleep_req && (sleep_target != ST_WORK))
         begin
            state_next = sleep_target;
            calls_next = 2'h0;
            grant_next = 1'b0;
         end
      end
      else if (wake_req)
      begin
         state_next = ST_WORK; // RQ8
         wake_next  = 1'b1;
         if ((state_reg == ST_APM_OFF) && ring_any)
         begin
            calls_next = CALLS_TO_GRANT - 2'h1; // RQ12
         end
         else if (rise[SRC_RING_A] || rise[SRC_MODIRQ])
         begin
            grant_next = 1'b1; // RQ16
         end
      end
      power_next = (state_next == ST_WORK) || (state_next == ST_S1);
      if (state_next == ST_WORK)
      begin
         led_next = LED_GREEN;
      end
      else if (state_next == ST_S3)
      begin
         led_next = sleep_led(dual_s) ? LED_AMBER : LED_OFF; // RQ9
      end
      else if (state_next == ST_S1 || state_next == ST_APM_SLP)
      begin
         led_next = dual_s ? LED_AMBER : LED_GREEN;
      end
      else
      begin
         led_next = LED_OFF;
      end
      sbled_next = standby_s; // RQ10
      if (reset)
      begin
         state_next = ST_WORK;
         wake_next  = 1'b0;
         calls_next = 2'h0;
         grant_next = 1'b0;
         power_next = 1'b1;
         led_next   = LED_GREEN;
         sbled_next = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      state_reg <= state_next;
      wake_reg  <= wake_next;
      calls_reg <= calls_next;
      grant_reg <= grant_next;
      power_reg <= power_next;
      led_reg   <= led_next;
      sbled_reg <= sbled_next;
   end

   assign state         = state_reg;
   assign main_power_on = power_reg;
   assign fans_on       = power_reg;
   assign front_led     = led_reg;
   assign standby_led   = sbled_reg;
   assign wake_pulse    = wake_reg;
   assign access_grant  = grant_reg;

   property p_mouse_s3;
      @(posedge clk) disable iff (reset)
      (state_reg == ST_S3) && rise[SRC_MOUSE] && !rise[SRC_PME]
      && !rise[SRC_USB] && !rise[SRC_KBD] |=> state_reg == ST_S3;
   endproperty
   a_mouse_s3: assert property (p_mouse_s3) // RQ4
      else $error("Mouse woke the system from S3.");

   property p_pme_s5;
      @(posedge clk) disable iff (reset)
      (state_reg == ST_S5) && rise[SRC_PME] && !jumper_s
      && !rise[SRC_LANCON] |=> state_reg == ST_S5;
   endproperty
   a_pme_s5: assert property (p_pme_s5) // RQ1
      else $error("Power event woke S5 without the jumper.");

   property p_usb_s3;
      @(posedge clk) disable iff (reset)
      (state_reg == ST_S3) && rise[SRC_USB]
      |=> state_reg == ST_WORK && wake_reg;
   endproperty
   a_usb_s3: assert property (p_usb_s3) // RQ2
      else $error("Serial bus activity did not wake from S3.");

   property p_kbd_s1;
      @(posedge clk) disable iff (reset)
      (state_reg == ST_S1) && rise[SRC_KBD] |=> state_reg == ST_WORK;
   endproperty
   a_kbd_s1: assert property (p_kbd_s1) // RQ3
      else $error("Keyboard did not wake from S1.");

   property p_lan_s3;
      @(posedge clk) disable iff (reset)
      (state_reg == ST_S3) && rise[SRC_LANCON] && !rise[SRC_PME]
      && !rise[SRC_USB] && !rise[SRC_KBD] |=> state_reg == ST_S3;
   endproperty
   a_lan_s3: assert property (p_lan_s3) // RQ6
      else $error("Network connector woke the system from S3.");

   property p_s3_dark;
      @(posedge clk) disable iff (reset)
      state_reg == ST_S3 |-> !power_reg && !fans_on
      && led_reg == ($past(dual_s) ? LED_AMBER : LED_OFF);
   endproperty
   a_s3_dark: assert property (p_s3_dark) // RQ9
      else $error("Supply, fans or indicator wrong in S3.");

   property p_standby;
      @(posedge clk) disable iff (reset)
      $rose(standby_s) |=> sbled_reg;
   endproperty
   a_standby: assert property (p_standby) // RQ10
      else $error("Standby indicator not lit.");

   sequence s_ring_wake;
      (state_reg == ST_APM_OFF) && rise[SRC_RING_A] ##1 state_reg == ST_WORK;
   endsequence

   property p_two_calls;
      @(posedge clk) disable iff (reset)
      s_ring_wake |-> !grant_reg;
   endproperty
   a_two_calls: assert property (p_two_calls) // RQ11 RQ12
      else $error("Access granted on the first ring wake call.");

   property p_port_b;
      @(posedge clk) disable iff (reset)
      (state_reg == ST_APM_OFF) && rise[SRC_RING_B] && !rise[SRC_LANCON]
      && !ring_any |=> (state_reg == ST_APM_OFF) && !wake_reg;
   endproperty
   a_port_b: assert property (p_port_b) // RQ13
      else $error("Second serial port ring woke the system.");

   property p_resume;
      @(posedge clk) disable iff (reset)
      (state_reg == ST_APM_SLP) && rise[SRC_RING_A]
      |=> state_reg == ST_WORK && grant_reg;
   endproperty
   a_resume: assert property (p_resume) // RQ15 RQ16
      else $error("Ring resume failed to grant on one call.");

endmodule : wake_event_logic

// File: logic/wake_pkg.sv
package wake_pkg;

   typedef enum logic [2:0]
   {
      ST_WORK    = 3'b000,
      ST_S1      = 3'b001,
      ST_S3      = 3'b011,
      ST_S5      = 3'b010,
      ST_APM_SLP = 3'b110,
      ST_APM_OFF = 3'b111
   } pwr_state_e;

   localparam int NUM_SRC     = 9;
   localparam int SRC_PME     = 0;
   localparam int SRC_USB     = 1;
   localparam int SRC_KBD     = 2;
   localparam int SRC_MOUSE   = 3;
   localparam int SRC_LANCON  = 4;
   localparam int SRC_RING_A  = 5;
   localparam int SRC_RING_B  = 6;
   localparam int SRC_RINGCON = 7;
   localparam int SRC_MODIRQ  = 8;

   localparam logic [1:0] LED_OFF   = 2'h0;
   localparam logic [1:0] LED_GREEN = 2'h1;
   localparam logic [1:0] LED_AMBER = 2'h2;

   localparam logic [1:0] CALLS_TO_GRANT = 2'h2;

endpackage : wake_pkg

// File: logic/sync_bank.sv
`timescale 1ns/1ps
module sync_bank
#(
   parameter int WIDTH = 9
)
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   always_comb
   begin
      meta_next = async_in;
      sync_next = meta_reg;
      if (reset)
      begin
         meta_next = '0;
         sync_next = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
   end

   assign sync_out = sync_reg;

endmodule : sync_bank

// File: test/wake_src_model.sv
`timescale 1ns/1ps
// Stands in for the wake sources: network adapter, modem and peripherals.
module wake_src_model
(
   input  wire logic clk,
   output logic      pme_n,
   output logic      usb_activity,
   output logic      kbd_activity,
   output logic      mouse_activity,
   output logic      lan_wake,
   output logic      ring_port_a,
   output logic      ring_port_b,
   output logic      ring_connector,
   output logic      modem_irq
);
   import wake_pkg::*;

   logic [NUM_SRC-1:0] act_reg = '0;

   // The bus power event line idles high through its pull-up.
   assign pme_n          = ~act_reg[SRC_PME];
   assign usb_activity   = act_reg[SRC_USB];
   assign kbd_activity   = act_reg[SRC_KBD];
   assign mouse_activity = act_reg[SRC_MOUSE];
   assign lan_wake       = act_reg[SRC_LANCON];
   assign ring_port_a    = act_reg[SRC_RING_A];
   assign ring_port_b    = act_reg[SRC_RING_B];
   assign ring_connector = act_reg[SRC_RINGCON];
   assign modem_irq      = act_reg[SRC_MODIRQ];

   // Held for four cycles so the two-flop synchroniser cannot miss it.
   task automatic strike(input int s);
      @(posedge clk);
      #1 act_reg[s] = 1'b1;
      repeat (4) @(posedge clk);
      #1 act_reg[s] = 1'b0;
   endtask : strike
endmodule : wake_src_model

// File: test/wake_event_logic_tb_top.sv
`timescale 1ns/1ps
module wake_event_logic_tb_top;
   import wake_pkg::*;

   logic       clk = 1'b0;
   logic       reset = 1'b1;
   logic       sleep_req = 1'b0;
   pwr_state_e sleep_target = ST_S1;
   logic       s5_jumper = 1'b0;
   logic       led_dual_colour = 1'b0;
   logic       standby_present = 1'b0;
   logic       access_ack = 1'b0;
   logic       pme_n, usb_activity, kbd_activity, mouse_activity, lan_wake;
   logic       ring_port_a, ring_port_b, ring_connector, modem_irq;
   pwr_state_e state;
   logic       main_power_on, fans_on, standby_led, wake_pulse, access_grant;
   logic [1:0] front_led;
   int         n_fail = 0;
   int         tests_run = 0;
   int         nwp = 0;

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   wake_src_model src_u (.clk(clk), .pme_n(pme_n),
      .usb_activity(usb_activity), .kbd_activity(kbd_activity),
      .mouse_activity(mouse_activity), .lan_wake(lan_wake),
      .ring_port_a(ring_port_a), .ring_port_b(ring_port_b),
      .ring_connector(ring_connector), .modem_irq(modem_irq));

   wake_event_logic dut_u (.clk(clk), .reset(reset), .sleep_req(sleep_req),
      .sleep_target(sleep_target), .pme_n(pme_n),
      .usb_activity(usb_activity), .kbd_activity(kbd_activity),
      .mouse_activity(mouse_activity), .lan_wake(lan_wake),
      .ring_port_a(ring_port_a), .ring_port_b(ring_port_b),
      .ring_connector(ring_connector), .modem_irq(modem_irq),
      .s5_jumper(s5_jumper), .led_dual_colour(led_dual_colour),
      .standby_present(standby_present), .access_ack(access_ack),
      .state(state), .main_power_on(main_power_on), .fans_on(fans_on),
      .front_led(front_led), .standby_led(standby_led),
      .wake_pulse(wake_pulse), .access_grant(access_grant));

   always @(posedge clk)
   begin
      if (wake_pulse === 1'b1)
         nwp++;
   end

   task automatic chk(input string what, input logic [3:0] seen,
                      input logic [3:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   // Sources allowed to wake from each sleep state, one bit per source.
   function automatic int wake_mask(pwr_state_e st, logic j);
      case (st)
         ST_S1:      return 'h12f;
         ST_S3:      return 'h007;
         ST_S5:      return 'h010 | int'(j);
         ST_APM_OFF: return 'h0b0;
         ST_APM_SLP: return 'h120;
         default:    return 0;
      endcase
   endfunction : wake_mask

   task automatic ack_grant();
      @(posedge clk);
      #1 access_ack = 1'b1;
      @(posedge clk);
      #1 access_ack = 1'b0;
      @(posedge clk);
      #1 chk("grant_cleared", access_grant, 1'b0);
   endtask : ack_grant

   initial
   begin
      #(25ns * 20000);
      n_fail++;
      test_done();
   end

   initial
   begin
      pwr_state_e sts[5];
      logic       ok, rr, armed, lit;
      logic [1:0] led_exp;
      sts = '{ST_S1, ST_S3, ST_S5, ST_APM_SLP, ST_APM_OFF};
      void'($urandom(32'hf9827dbc));
      repeat (16) @(posedge clk);
      foreach (sts[i])
         for (int s = 0; s < NUM_SRC; s++)
            for (int j = 0; j < 2; j++)
            begin
               #1 reset = 1'b1;
               s5_jumper = j[0];
               led_dual_colour = 1'($urandom);
               standby_present = 1'($urandom);
               repeat (4) @(posedge clk);
               #1 reset = 1'b0;
               sleep_req = 1'b1;
               sleep_target = sts[i];
               @(posedge clk);
               #1 sleep_req = 1'b0;
               repeat (2) @(posedge clk);
               #1 chk("sleep_state", state, sts[i]);
               lit = (sts[i] == ST_S1);
               chk("main_power", main_power_on, lit);
               chk("fans", fans_on, lit);
               chk("standby_led", standby_led, standby_present);
               led_dual_colour = ~led_dual_colour;
               led_exp = (sts[i] == ST_S3) ? LED_OFF : LED_GREEN;
               if (led_dual_colour)
                  led_exp = LED_AMBER;
               if (sts[i] inside {ST_S1, ST_S3, ST_APM_SLP})
               begin
                  repeat (4) @(posedge clk);
                  #1 chk("front_led", front_led, led_exp);
               end
               nwp = 0;
               ok = wake_mask(sts[i], j[0]) >> s;
               rr = (s == SRC_RING_A || s == SRC_MODIRQ)
                    && (sts[i] inside {ST_S1, ST_APM_SLP});
               armed = ok && sts[i] == ST_APM_OFF
                       && (s == SRC_RING_A || s == SRC_RINGCON);
               src_u.strike(s);
               repeat (4) @(posedge clk);
               #1 chk("wake_count", nwp, ok);
               chk("woken_state", state, ok ? ST_WORK : sts[i]);
               chk("resume_grant", access_grant, ok && rr);
               if (ok)
                  chk("power_back", main_power_on, 1'b1);
               if (armed)
               begin
                  src_u.strike(SRC_RING_A);
                  repeat (4) @(posedge clk);
                  #1 chk("second_call", access_grant, 1'b1);
               end
               if (ok && (rr || armed))
                  ack_grant();
            end
      test_done();
   end
endmodule : wake_event_logic_tb_top
